// *** cfg_access_pkg.sv ***
/*
 * Shared constants and carriers for the configuration index/data access unit:
 * bus structs, register indices, field positions, strap default tables and
 * the I/O port map of the decoded functions.
 * Assumes a 12-bit AXI4-Lite byte address in which each I/O port is one word.
 */
package cfg_access_pkg;

	// axi4-lite carriers
	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axi_rsp_t;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// configuration registers as seen by the rest of the chip
	typedef struct packed {
		logic [7:0] function_enable_reg;
		logic [7:0] function_address_reg;
		logic [7:0] ptr;
		logic [7:0] function_control_reg;
		logic [7:0] printer_control_reg;
		logic [7:0] power_mgmt_control_reg;
		logic [7:0] tape_uart_port_config_reg;
	} cfg_regs_t;

	typedef struct packed {
		logic fdc;
		logic ide;
		logic uart_a;
		logic uart_b;
		logic printer;
	} func_set_t;

	// configuration register indices
	localparam logic [7:0] IDX_FER = 8'h00;
	localparam logic [7:0] IDX_FAR = 8'h01;
	localparam logic [7:0] IDX_PTR = 8'h02;
	localparam logic [7:0] IDX_FCR = 8'h03;
	localparam logic [7:0] IDX_PCR = 8'h04;
	localparam logic [7:0] IDX_PMC = 8'h05;
	localparam logic [7:0] IDX_TUP = 8'h06;
	localparam logic [7:0] IDX_SID = 8'h07;

	// index register: bits 4-6 reserved, read zero
	localparam logic [7:0] INDEX_MASK = 8'h8f;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	// arbitrary values standing in for the identification codes
	localparam logic [7:0] ID_BYTE = 8'h5a;
	localparam logic [7:0] SID_VALUE = 8'ha5;

	// field positions
	localparam int FER_PRINTER_BIT = 0;
	localparam int FER_UART_A_BIT = 1;
	localparam int FER_UART_B_BIT = 2;
	localparam int FER_FDC_BIT = 3;
	localparam int FER_IDE_BIT = 6;
	localparam int FER_IDE_SEC_BIT = 7;
	localparam int FAR_PRINTER_LSB = 0;
	localparam int FAR_UART_A_LSB = 2;
	localparam int FAR_UART_B_LSB = 4;
	localparam int PTR_OSC_STOP_BIT = 1;
	localparam int FCR_POWER_DOWN_INPUT_SEL_BIT = 6;
	localparam logic [1:0] PRN_CODE_A = 2'h1;
	localparam logic [1:0] PRN_CODE_B = 2'h0;

	// strap default tables, entry n for strap code n
	localparam logic [31:0][7:0] STRAP_FER = {
		8'h00, 8'h08, 8'hc7, 8'h47, 8'h47, 8'hc7, 8'h47, 8'h47,
		8'h07, 8'h07, 8'h07, 8'h07, 8'hc9, 8'hc9, 8'h49, 8'h49,
		8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'hcb, 8'h4b, 8'h4b, 8'hcb,
		8'h4b, 8'h4b, 8'hcf, 8'h4f, 8'h4f, 8'hcf, 8'h4f, 8'h4f};
	localparam logic [31:0][7:0] STRAP_FAR = {
		8'h10, 8'h10, 8'h38, 8'h24, 8'h39, 8'h11, 8'h11, 8'h10,
		8'h24, 8'h39, 8'h11, 8'h10, 8'h00, 8'h01, 8'h01, 8'h00,
		8'h24, 8'h39, 8'h11, 8'h10, 8'h08, 8'h08, 8'h09, 8'h01,
		8'h01, 8'h00, 8'h38, 8'h24, 8'h39, 8'h11, 8'h11, 8'h10};
	localparam logic [7:0] PTR_DEFAULT_ACTIVE = 8'h00;
	localparam logic [7:0] PTR_DEFAULT_NONE = 8'h02;
	localparam logic [7:0] SW_ONLY_RESET = 8'h00;

	// i/o port map
	localparam logic [3:0][9:0] PAIR_INDEX_PORT = {10'h02e, 10'h15c, 10'h26e, 10'h398};
	localparam logic [9:0] PAIR_DATA_OFFSET = 10'h001;
	localparam logic [9:0] FDC_BASE = 10'h3f0;
	localparam logic [9:0] IDE_PRI_CMD = 10'h1f0;
	localparam logic [9:0] IDE_PRI_CTL = 10'h3f6;
	localparam logic [9:0] IDE_SEC_CMD = 10'h170;
	localparam logic [9:0] IDE_SEC_CTL = 10'h376;
	localparam logic [3:0][9:0] UART_BASE = {10'h2e8, 10'h3e8, 10'h2f8, 10'h3f8};
	localparam logic [9:0] PRN_A_FIRST = 10'h3bc;
	localparam logic [9:0] PRN_A_LAST = 10'h3be;
	localparam logic [9:0] PRN_B_BASE = 10'h378;

endpackage

// *** config_index_data_access.sv ***
/*
 * Configuration index/data access unit: index/data register pair reached
 * over AXI4-Lite, strap defaults, two-write commit, function address decode
 * and the shared zero-wait / power-down pin.
 * Assumes each I/O port sits at byte address 4*port, straps are stable while
 * aresetn is low, and all inputs are synchronous to aclk.
 */
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
// Summary of operation
// - during reset load strap-selected defaults into enable, address and power regs
// - control, printer, power, tape and id registers get fixed defaults only
// - index picks the configuration register, data port moves its contents
// - first index read after reset returns the id byte unless written first
// - second index read after reset returns zero
// - otherwise index read returns last written index
// - index bits four to six read zero except in the id byte
// - register changes only on second identical consecutive data write
// - single reads allowed any time and never change register contents
// - data read returns the register selected by the index
// - two-write updates can replace strap defaults any time after reset
// - power-down input stops all function clocks
// - with no functions strapped, power-down also stops the oscillator
// - enable register picks primary or secondary ide range
// - decode the one fixed floppy range, and the ide primary or secondary ranges
// - uart selections decode eight ports at one of four bases
// - printer decodes one of two ranges by its address code
// - control bit six clear: shared pin is open-drain zero-wait output
// - control bit six set: shared pin is the power-down input
// - base straps place the index/data pair at one of four ports
// - disabled functions lose clocks and selects but keep contents
`timescale 1ns/1ps
`default_nettype none

module config_index_data_access (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire cfg_access_pkg::axi_req_t s_axi_req,
	output var cfg_access_pkg::axi_rsp_t s_axi_rsp,
	// straps
	input wire logic [4:0] config_strap_pins,
	input wire logic [1:0] base_address_straps,
	// peripheral decode
	input wire logic [9:0] periph_addr,
	input wire logic epp_fast_write,
	// shared zero-wait / power-down pin
	input wire logic zero_wait_in,
	output var logic zero_wait_out,
	output var logic zero_wait_oe_n,
	// function control
	output var cfg_access_pkg::func_set_t func_select,
	output var cfg_access_pkg::func_set_t func_clock_en,
	output var logic osc_stop,
	output var cfg_access_pkg::cfg_regs_t cfg_out
);
	import cfg_access_pkg::*;

	typedef struct packed {
		cfg_regs_t cfg;
		logic [7:0] index;
		logic id_pending;
		logic wr_pending;
		logic [7:0] wr_first;
		logic [1:0] base_sel;
		logic aw_held;
		logic [11:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic ar_held;
		logic [11:0] araddr;
		axi_rsp_t rsp;
		func_set_t sel;
		func_set_t clk_en;
		logic osc_stop;
		logic zws_level;
		logic zws_oe_n;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic [9:0] index_port;
	logic [9:0] data_port;
	logic [9:0] wr_port;
	logic [9:0] rd_port;
	logic wr_exec;
	logic rd_exec;
	logic power_down;
	logic ide_sec;
	logic [7:0] strap_fer;

	function automatic logic [7:0] read_cfg(input state_t s);
		case (s.index)
			IDX_FER: read_cfg = s.cfg.function_enable_reg;
			IDX_FAR: read_cfg = s.cfg.function_address_reg;
			IDX_PTR: read_cfg = s.cfg.ptr;
			IDX_FCR: read_cfg = s.cfg.function_control_reg;
			IDX_PCR: read_cfg = s.cfg.printer_control_reg;
			IDX_PMC: read_cfg = s.cfg.power_mgmt_control_reg;
			IDX_TUP: read_cfg = s.cfg.tape_uart_port_config_reg;
			IDX_SID: read_cfg = SID_VALUE;
			default: read_cfg = 8'h00;
		endcase
	endfunction

	// the id register and indices without a register silently drop the write
	function automatic cfg_regs_t commit(input cfg_regs_t c, input logic [7:0] idx,
			input logic [7:0] d);
		commit = c;
		case (idx)
			IDX_FER: commit.function_enable_reg = d;
			IDX_FAR: commit.function_address_reg = d;
			IDX_PTR: commit.ptr = d;
			IDX_FCR: commit.function_control_reg = d;
			IDX_PCR: commit.printer_control_reg = d;
			IDX_PMC: commit.power_mgmt_control_reg = d;
			IDX_TUP: commit.tape_uart_port_config_reg = d;
			default: commit = c;
		endcase
	endfunction

	function automatic logic uart_hit(input logic [9:0] a, input logic [1:0] code);
		uart_hit = (a[9:3] == UART_BASE[code][9:3]);
	endfunction

	always_comb begin
		index_port = PAIR_INDEX_PORT[state_reg.base_sel];
		data_port = index_port + PAIR_DATA_OFFSET;
		wr_port = state_reg.awaddr[11:2];
		rd_port = state_reg.araddr[11:2];
		wr_exec = state_reg.aw_held && state_reg.w_held && !state_reg.rsp.bvalid;
		// a write in the same cycle goes first so the pending flag sees one order
		rd_exec = state_reg.ar_held && !state_reg.rsp.rvalid && !wr_exec;
		power_down = state_reg.cfg.function_control_reg[FCR_POWER_DOWN_INPUT_SEL_BIT] && !zero_wait_in;
		ide_sec = state_reg.cfg.function_enable_reg[FER_IDE_SEC_BIT];
		strap_fer = STRAP_FER[config_strap_pins];
		state_next = state_reg;

		// response channels drain
		if (state_reg.rsp.bvalid && s_axi_req.bready) begin
			state_next.rsp.bvalid = 1'b0;
		end
		if (state_reg.rsp.rvalid && s_axi_req.rready) begin
			state_next.rsp.rvalid = 1'b0;
		end

		// write execution
		if (wr_exec) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.rsp.bvalid = 1'b1;
			state_next.rsp.bresp = RESP_OKAY;
			state_next.wr_pending = 1'b0;
			if (wr_port == index_port) begin
				if (state_reg.wstrb0) begin
					state_next.index = state_reg.wdata & INDEX_MASK;
					state_next.id_pending = 1'b0;
				end
			end else if (wr_port == data_port) begin
				if (state_reg.wstrb0) begin
					if (state_reg.wr_pending && state_reg.wr_first == state_reg.wdata) begin
						state_next.cfg = commit(state_reg.cfg, state_reg.index,
							state_reg.wdata);
					end else begin
						state_next.wr_pending = 1'b1;
						state_next.wr_first = state_reg.wdata;
					end
				end
			end else begin
				state_next.rsp.bresp = RESP_DECERR;
			end
		end

		// read execution has no effect on stored configuration
		if (rd_exec) begin
			state_next.ar_held = 1'b0;
			state_next.rsp.rvalid = 1'b1;
			state_next.rsp.rresp = RESP_OKAY;
			state_next.rsp.rdata = 32'h0000_0000;
			state_next.wr_pending = 1'b0;
			if (rd_port == index_port) begin
				if (state_reg.id_pending) begin
					state_next.rsp.rdata[7:0] = ID_BYTE;
					state_next.id_pending = 1'b0;
				end else begin
					state_next.rsp.rdata[7:0] = state_reg.index;
				end
			end else if (rd_port == data_port) begin
				state_next.rsp.rdata[7:0] = read_cfg(state_reg);
			end else begin
				state_next.rsp.rresp = RESP_DECERR;
			end
		end

		// request channels; one transfer of each direction in flight
		if (s_axi_req.awvalid && state_reg.rsp.awready) begin
			state_next.aw_held = 1'b1;
			state_next.awaddr = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && state_reg.rsp.wready) begin
			state_next.w_held = 1'b1;
			state_next.wdata = s_axi_req.wdata[7:0];
			state_next.wstrb0 = s_axi_req.wstrb[0];
		end
		if (s_axi_req.arvalid && state_reg.rsp.arready) begin
			state_next.ar_held = 1'b1;
			state_next.araddr = s_axi_req.araddr;
		end
		state_next.rsp.awready = !state_next.aw_held && !state_next.rsp.bvalid;
		state_next.rsp.wready = !state_next.w_held && !state_next.rsp.bvalid;
		state_next.rsp.arready = !state_next.ar_held && !state_next.rsp.rvalid;

		// function decode, gated by enables; contents of disabled units stay put
		state_next.sel.fdc = state_reg.cfg.function_enable_reg[FER_FDC_BIT]
			&& periph_addr[9:3] == FDC_BASE[9:3];
		if (ide_sec) begin
			state_next.sel.ide = state_reg.cfg.function_enable_reg[FER_IDE_BIT]
				&& (periph_addr[9:3] == IDE_SEC_CMD[9:3]
				|| periph_addr[9:1] == IDE_SEC_CTL[9:1]);
		end else begin
			state_next.sel.ide = state_reg.cfg.function_enable_reg[FER_IDE_BIT]
				&& (periph_addr[9:3] == IDE_PRI_CMD[9:3]
				|| periph_addr[9:1] == IDE_PRI_CTL[9:1]);
		end
		state_next.sel.uart_a = state_reg.cfg.function_enable_reg[FER_UART_A_BIT]
			&& uart_hit(periph_addr, state_reg.cfg.function_address_reg[FAR_UART_A_LSB +: 2]);
		state_next.sel.uart_b = state_reg.cfg.function_enable_reg[FER_UART_B_BIT]
			&& uart_hit(periph_addr, state_reg.cfg.function_address_reg[FAR_UART_B_LSB +: 2]);
		// the two unused printer codes decode nothing
		case (state_reg.cfg.function_address_reg[FAR_PRINTER_LSB +: 2])
			PRN_CODE_A: begin
				state_next.sel.printer = periph_addr >= PRN_A_FIRST
					&& periph_addr <= PRN_A_LAST;
			end
			PRN_CODE_B: begin
				state_next.sel.printer = periph_addr[9:3] == PRN_B_BASE[9:3];
			end
			default: begin
				state_next.sel.printer = 1'b0;
			end
		endcase
		state_next.sel.printer = state_next.sel.printer
			&& state_reg.cfg.function_enable_reg[FER_PRINTER_BIT];

		// clock gating
		state_next.clk_en.fdc = state_reg.cfg.function_enable_reg[FER_FDC_BIT] && !power_down;
		state_next.clk_en.ide = state_reg.cfg.function_enable_reg[FER_IDE_BIT] && !power_down;
		state_next.clk_en.uart_a = state_reg.cfg.function_enable_reg[FER_UART_A_BIT] && !power_down;
		state_next.clk_en.uart_b = state_reg.cfg.function_enable_reg[FER_UART_B_BIT] && !power_down;
		state_next.clk_en.printer = state_reg.cfg.function_enable_reg[FER_PRINTER_BIT] && !power_down;
		state_next.osc_stop = power_down && state_reg.cfg.ptr[PTR_OSC_STOP_BIT];

		// open drain: only ever pulls low, never drives high
		state_next.zws_level = 1'b0;
		state_next.zws_oe_n = !(!state_reg.cfg.function_control_reg[FCR_POWER_DOWN_INPUT_SEL_BIT] && epp_fast_write);

		// synchronous reset; straps only matter while it is held
		if (!aresetn) begin
			state_next = '0;
			state_next.cfg.function_enable_reg = strap_fer;
			state_next.cfg.function_address_reg = STRAP_FAR[config_strap_pins];
			if (strap_fer == 8'h00) begin
				state_next.cfg.ptr = PTR_DEFAULT_NONE;
			end else begin
				state_next.cfg.ptr = PTR_DEFAULT_ACTIVE;
			end
			state_next.cfg.function_control_reg = SW_ONLY_RESET;
			state_next.cfg.printer_control_reg = SW_ONLY_RESET;
			state_next.cfg.power_mgmt_control_reg = SW_ONLY_RESET;
			state_next.cfg.tape_uart_port_config_reg = SW_ONLY_RESET;
			state_next.base_sel = base_address_straps;
			state_next.index = INDEX_RESET;
			state_next.id_pending = 1'b1;
			state_next.wr_pending = 1'b0;
			state_next.zws_oe_n = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		state_reg <= state_next;
	end

	assign s_axi_rsp = state_reg.rsp;
	assign zero_wait_out = state_reg.zws_level;
	assign zero_wait_oe_n = state_reg.zws_oe_n;
	assign func_select = state_reg.sel;
	assign func_clock_en = state_reg.clk_en;
	assign osc_stop = state_reg.osc_stop;
	assign cfg_out = state_reg.cfg;

endmodule // config_index_data_access

`default_nettype wire

// *** cfg_access_assertions.sv ***
/* checker for the configuration access unit
   assumes it is bound onto config_index_data_access, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module cfg_access_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire cfg_access_pkg::axi_req_t s_axi_req,
	input wire cfg_access_pkg::axi_rsp_t s_axi_rsp,
	// straps
	input wire logic [4:0] config_strap_pins,
	input wire logic [1:0] base_address_straps,
	// peripheral decode
	input wire logic [9:0] periph_addr,
	input wire logic epp_fast_write,
	// shared pin
	input wire logic zero_wait_in,
	input wire logic zero_wait_out,
	input wire logic zero_wait_oe_n,
	// function control
	input wire cfg_access_pkg::func_set_t func_select,
	input wire cfg_access_pkg::func_set_t func_clock_en,
	input wire logic osc_stop,
	input wire cfg_access_pkg::cfg_regs_t cfg_out
);
	import cfg_access_pkg::*;
	wire logic [7:0] en_bits = cfg_out.function_enable_reg;
	wire logic [7:0] addr_sel = cfg_out.function_address_reg;
	// power-down only counts while the pin serves as the input
	wire logic pd = cfg_out.function_control_reg[FCR_POWER_DOWN_INPUT_SEL_BIT] && !zero_wait_in;
	wire logic aw_w = s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
	wire logic ar_hs = s_axi_req.arvalid && s_axi_rsp.arready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the held request executes one cycle after the handshake, the answer registers a cycle later
	a_write_answer: assert property (aw_w |-> ##2 s_axi_rsp.bvalid)
		else $error("write not answered");
	a_read_answer: assert property (ar_hs |-> ##[2:3] s_axi_rsp.rvalid)
		else $error("read not answered");
	a_zws_drive: assert property (
		!cfg_out.function_control_reg[FCR_POWER_DOWN_INPUT_SEL_BIT] && epp_fast_write |=> !zero_wait_oe_n && !zero_wait_out)
		else $error("zero wait not driven");
	a_zws_release: assert property (cfg_out.function_control_reg[FCR_POWER_DOWN_INPUT_SEL_BIT] |=> zero_wait_oe_n)
		else $error("pin driven in power-down role");
	a_power_down_input_clocks: assert property (pd |=> func_clock_en == '0)
		else $error("clocks run in power-down");
	a_osc_cause: assert property (osc_stop == $past(pd && cfg_out.ptr[PTR_OSC_STOP_BIT]))
		else $error("oscillator stop wrong");
	a_fdc_decode: assert property (
		en_bits[FER_FDC_BIT] && periph_addr[9:3] == FDC_BASE[9:3] |=> func_select.fdc)
		else $error("floppy range not decoded");
	a_uart_decode: assert property (
		en_bits[FER_UART_A_BIT] && periph_addr[9:3] == UART_BASE[addr_sel[3:2]][9:3]
		|=> func_select.uart_a)
		else $error("serial range not decoded");
	a_disabled_func: assert property (
		!en_bits[FER_FDC_BIT] |=> !func_select.fdc && !func_clock_en.fdc)
		else $error("disabled function active");
	c_write: cover property (s_axi_rsp.bvalid && s_axi_req.bready);
	c_osc: cover property (osc_stop);
	c_zws: cover property (!zero_wait_oe_n);
endmodule // cfg_access_checker
`default_nettype wire

// *** host_master_model.sv ***
/* host cpu model: one register bus access at a time
   assumes the testbench calls its tasks and checks the outcome */
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
	// clock
	input wire logic aclk,
	// register bus
	output var cfg_access_pkg::axi_req_t req,
	input wire cfg_access_pkg::axi_rsp_t rsp
);
	import cfg_access_pkg::*;
	initial req = '0;
	// a task returns after its response or after 100 cycles without one, so no access overlaps another
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		r = '1;
		@(posedge aclk);
		req.awaddr <= a;
		req.awvalid <= 1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'h1;
		req.wvalid <= 1;
		req.bready <= 1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) begin
				req.awvalid <= 0;
				req.awaddr <= ~a;
			end
			if (req.wvalid && rsp.wready) begin
				req.wvalid <= 0;
				req.wdata <= ~{24'h0, d};
			end
			if (rsp.bvalid) begin
				req.bready <= 0;
				r = rsp.bresp;
				ok = 1;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
		output bit ok);
		ok = 0;
		d = '1;
		r = '1;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1;
		req.rready <= 1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) begin
				req.arvalid <= 0;
				req.araddr <= ~a;
			end
			if (rsp.rvalid) begin
				req.rready <= 0;
				d = rsp.rdata;
				r = rsp.rresp;
				ok = 1;
			end
		end
	endtask
endmodule // host_master_model
`default_nettype wire

// *** tb.sv ***
/* testbench for the configuration access unit
   assumes the host model drives the bus and the checker is bound below */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cfg_access_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	axi_req_t req;
	axi_rsp_t rsp;
	logic [4:0] straps = '0;
	logic [1:0] base = '0;
	logic [9:0] paddr = '0;
	logic epp = 0;
	logic zw_in = 1;
	logic zw_out, zw_oe_n, osc;
	func_set_t fsel, fclk;
	cfg_regs_t regs;
	logic [9:0] ip, dp;
	int n_errors = 0;
	int n_compared = 0;
	always #4 aclk = ~aclk;
	config_index_data_access i_config_index_data_access (.aclk(aclk), .aresetn(aresetn),
		.s_axi_req(req), .s_axi_rsp(rsp), .config_strap_pins(straps),
		.base_address_straps(base), .periph_addr(paddr), .epp_fast_write(epp),
		.zero_wait_in(zw_in), .zero_wait_out(zw_out), .zero_wait_oe_n(zw_oe_n),
		.func_select(fsel), .func_clock_en(fclk), .osc_stop(osc), .cfg_out(regs));
	host_master_model i_host_master_model (.aclk(aclk), .req(req), .rsp(rsp));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang(input bit ok);
		if (!ok) begin
			n_errors++;
			final_report();
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic bw(input logic [9:0] p, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit ok;
		i_host_master_model.wr({p, 2'h0}, d, r, ok);
		hang(ok);
		chk(r, er);
	endtask
	task automatic br(input logic [9:0] p, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		bit ok;
		i_host_master_model.rd({p, 2'h0}, d, r, ok);
		hang(ok);
		chk(d, e);
		chk(r, er);
	endtask
	task automatic do_reset(input logic [4:0] s, input logic [1:0] b, input logic [9:0] p);
		@(posedge aclk);
		aresetn <= 0;
		straps <= s;
		base <= b;
		ip = p;
		dp = p + 10'h1;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		idle(2);
	endtask
	task automatic t_defaults(input logic [7:0] f, input logic [7:0] a, input logic [7:0] t);
		chk({regs.function_enable_reg, regs.function_address_reg, regs.ptr}, {8'h0, f, a, t});
		chk({regs.function_control_reg, regs.printer_control_reg, regs.power_mgmt_control_reg, regs.tape_uart_port_config_reg}, 32'h0);
	endtask
	task automatic t_id;
		br(ip, {24'h0, ID_BYTE}, RESP_OKAY);
		br(ip, 32'h0, RESP_OKAY);
		bw(ip, 8'hf3, RESP_OKAY);
		br(ip, 32'h83, RESP_OKAY);
		bw(ip, IDX_SID, RESP_OKAY);
		br(dp, {24'h0, SID_VALUE}, RESP_OKAY);
	endtask
	task automatic t_commit;
		bw(ip, IDX_PCR, RESP_OKAY);
		bw(dp, 8'h3c, RESP_OKAY);
		br(dp, 32'h0, RESP_OKAY);
		bw(dp, 8'h3c, RESP_OKAY);
		idle(2);
		chk(regs.printer_control_reg, 32'h0);
		bw(dp, 8'h3c, RESP_OKAY);
		idle(2);
		chk(regs.printer_control_reg, 32'h3c);
		bw(dp, 8'h11, RESP_OKAY);
		bw(ip, IDX_PCR, RESP_OKAY);
		bw(dp, 8'h11, RESP_OKAY);
		br(dp, 32'h3c, RESP_OKAY);
		br(10'h000, 32'h0, RESP_DECERR);
		bw(10'h000, 8'h55, RESP_DECERR);
		bw(ip, IDX_FAR, RESP_OKAY);
		bw(dp, 8'h24, RESP_OKAY);
		bw(dp, 8'h24, RESP_OKAY);
		idle(2);
		chk(regs.function_address_reg, 32'h24);
	endtask
	task automatic t_decode;
		logic [9:0] a[6] = '{10'h3f2, 10'h1f7, 10'h2ff, 10'h3e8, 10'h37f, 10'h3f8};
		logic [4:0] e[6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
		for (int k = 0; k < 6; k++) begin
			@(posedge aclk);
			paddr <= a[k];
			idle(2);
			chk(fsel, e[k]);
		end
	endtask
	task automatic t_zws;
		@(posedge aclk);
		epp <= 1;
		idle(2);
		chk({zw_oe_n, zw_out}, 32'h0);
		@(posedge aclk);
		epp <= 0;
		bw(ip, IDX_FCR, RESP_OKAY);
		bw(dp, 8'h40, RESP_OKAY);
		bw(dp, 8'h40, RESP_OKAY);
		@(posedge aclk);
		epp <= 1;
		zw_in <= 0;
		idle(2);
		chk({zw_oe_n, fclk}, 32'h20);
		@(posedge aclk);
		zw_in <= 1;
		epp <= 0;
		idle(2);
		chk(fclk, 32'h1f);
	endtask
	task automatic t_second;
		do_reset(5'h1f, 2'h3, 10'h02e);
		t_defaults(8'h00, 8'h10, 8'h02);
		@(posedge aclk);
		straps <= 5'h00;
		paddr <= 10'h3f0;
		idle(3);
		chk({regs.function_enable_reg, fsel}, 32'h0);
		bw(ip, IDX_FCR, RESP_OKAY);
		br(ip, 32'h03, RESP_OKAY);
		bw(dp, 8'h40, RESP_OKAY);
		bw(dp, 8'h40, RESP_OKAY);
		@(posedge aclk);
		zw_in <= 0;
		idle(2);
		chk({osc, fclk}, 32'h20);
	endtask
	initial begin
		do_reset(5'h00, 2'h0, 10'h398);
		t_defaults(8'h4f, 8'h10, 8'h00);
		t_id();
		t_commit();
		t_decode();
		t_zws();
		t_second();
		final_report();
	end
endmodule // tb
bind config_index_data_access cfg_access_checker i_cfg_access_checker (.aclk(aclk),
	.aresetn(aresetn), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
	.config_strap_pins(config_strap_pins), .base_address_straps(base_address_straps),
	.periph_addr(periph_addr), .epp_fast_write(epp_fast_write),
	.zero_wait_in(zero_wait_in), .zero_wait_out(zero_wait_out),
	.zero_wait_oe_n(zero_wait_oe_n), .func_select(func_select),
	.func_clock_en(func_clock_en), .osc_stop(osc_stop), .cfg_out(cfg_out));
`default_nettype wire
